// ### alb_pkg.sv
// package: types and constants of the arithmetic, logic and branch execution unit
package alb_pkg;
  // datapath widths
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int PC_W = 16;
  localparam int OFFS_W = 12;
  localparam int IO_ADDR_W = 6;
  localparam int BIT_SEL_W = 3;
  localparam int CNT_W = 3;

  // status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_S = 4;
  localparam int SR_H = 5;
  localparam int SR_T = 6;
  localparam int SR_I = 7;

  // reset values
  localparam logic [DATA_W-1:0] SREG_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;

  // constants of the operations
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
  localparam logic [5:0] WORD_IMM_MASK = 6'h3f;
  localparam logic [IO_ADDR_W-1:0] IO_BIT_LIMIT = 6'h1f;
  localparam logic [IO_ADDR_W-1:0] FLAG_REG_ADDR = 6'h08;
  localparam logic [PC_W-1:0] PC_STEP1 = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP2 = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP3 = 16'h0003;

  // cycle counts
  localparam logic [CNT_W-1:0] CYC_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CYC_TWO = 3'h2;
  localparam logic [CNT_W-1:0] CYC_THREE = 3'h3;
  localparam logic [CNT_W-1:0] CYC_FOUR = 3'h4;

  // operations carried out
  typedef enum logic [4:0] {
    op_add, op_add_carry, op_add_immediate_word, op_subtract,
    op_subtract_immediate, op_subtract_with_carry, op_subtract_carry_immediate,
    op_subtract_immediate_word, op_bitwise_mask_immediate, op_bitwise_merge_immediate,
    op_set_bits_instruction, op_clear_bits_instruction, op_compare_immediate,
    op_compare_skip_equal, op_skip_if_bit_low, op_indirect_jump, op_indirect_call,
    op_relative_jump, op_relative_call, op_subroutine_return, op_interrupt_return,
    op_io_bit_set, op_io_bit_clear
  } alb_op_type;

  // one decoded instruction with its operands
  typedef struct packed {
    alb_op_type op;
    logic [DATA_W-1:0] dest_val;
    logic [DATA_W-1:0] source_reg;
    logic [DATA_W-1:0] imm;
    logic [WORD_W-1:0] pair_val;
    logic [WORD_W-1:0] z_ptr;
    logic [OFFS_W-1:0] rel_offs;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] io_rdata;
    logic next_two_word;
  } alb_cmd_type;

  // register file write-back
  typedef struct packed {
    logic en;
    logic word;
    logic [WORD_W-1:0] data;
  } alb_wb_type;

  // I/O space write
  typedef struct packed {
    logic en;
    logic [IO_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } alb_io_wr_type;

  // adder result with flags
  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } alb_alu_type;
endpackage : alb_pkg

// ### alb_w1c_flags.sv
// status flags set by hardware and cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module alb_w1c_flags
  import alb_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // hardware events and software write
  input wire logic [WIDTH-1:0] set_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // flag state
  output logic [WIDTH-1:0] flags_o
);
  logic [WIDTH-1:0] clear_mask;

  // a one clears, a zero leaves the flag alone
  assign clear_mask = wr_en_i ? wr_data_i : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= WIDTH'(FLAGS_RESET);
    end else begin
      flags_o <= (flags_o & ~clear_mask) | set_i;
    end
  end
endmodule : alb_w1c_flags
`default_nettype wire

// ### alb_exec.sv
// execution unit for arithmetic, logic, jump, call, compare and skip instructions
// How it works
// - add with carry: dest+src+C in one clock, flags Z C N V H
// - add immediate to word pair, two clocks, flags Z C N V S
// - subtract immediate from dest in one clock, flags Z C N V H
// - subtract with carry registers: dest-src-C, one clock, flags Z C N V H
// - subtract with carry immediate: dest-K-C, one clock, flags Z C N V H
// - subtract immediate from word pair, two clocks, flags Z C N V S
// - AND with immediate, one clock, flags Z N V only
// - OR with immediate, one clock, flags Z N V only
// - set bits: OR mask into dest, one clock, flags Z N V
// - clear bits: AND with all-ones minus mask, one clock, flags Z N V
// - compare immediate: dest-K not stored, one clock, flags Z N V C H
// - compare skip if equal: PC+2 or +3 on skip, 1/2/3 clocks, no flags
// - skip if register bit low: 1/2/3 clocks, no flags
// - indirect jump: PC from Z pointer, two clocks, no flags
// - indirect call: push return, PC from Z, three clocks, no flags
// - write one clears a status flag, write zero leaves it
// - I/O bit set/clear rewrites the whole register, clearing flags read set except the bit that a bit clear addresses
// - I/O bit set/clear only reach I/O addresses 0 to 31
`timescale 1ns/1ps
`default_nettype none
module alb_exec
  import alb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // instruction in
  input wire logic cmd_valid_i,
  input wire alb_cmd_type cmd_i,
  // hardware events for the status flags
  input wire logic [DATA_W-1:0] flag_event_i,
  // handshake
  output logic ready_o,
  output logic done_o,
  // results
  output alb_wb_type wb_o,
  output logic [DATA_W-1:0] sreg_o,
  output logic [PC_W-1:0] pc_o,
  output alb_io_wr_type io_wr_o,
  output logic io_refused_o,
  output logic [DATA_W-1:0] status_flags_o
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  typedef enum logic {st_idle, st_wait} alb_state_type;

  alb_state_type state;
  logic [CNT_W-1:0] cnt;
  logic accept;
  logic commit;
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [DATA_W-1:0] flag_state;
  logic flag_wr_en;
  logic [DATA_W-1:0] flag_wr_data;

  // staged result of the instruction in flight
  alb_wb_type pend_wb;
  logic [DATA_W-1:0] pend_sreg;
  logic [PC_W-1:0] pend_pc;
  alb_io_wr_type pend_io;
  logic pend_refused;
  logic pend_push;
  logic pend_pop;

  // computed from the incoming instruction
  alb_wb_type next_wb;
  logic [DATA_W-1:0] next_sreg;
  logic [PC_W-1:0] next_pc;
  alb_io_wr_type next_io;
  logic next_refused;
  logic next_push;
  logic next_pop;
  logic [CNT_W-1:0] next_cycles;

  // 8-bit add with carry in, flags from the result
  function automatic alb_alu_type add8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                       input logic ci);
    alb_alu_type r;
    r.res = a + b + {7'h00, ci};
    r.h = (a[3] & b[3]) | (b[3] & ~r.res[3]) | (~r.res[3] & a[3]);
    r.c = (a[7] & b[7]) | (b[7] & ~r.res[7]) | (~r.res[7] & a[7]);
    r.v = (a[7] & b[7] & ~r.res[7]) | (~a[7] & ~b[7] & r.res[7]);
    r.n = r.res[7];
    r.z = (r.res == 8'h00);
    return r;
  endfunction : add8

  // 8-bit subtract with borrow in, flags from the result
  function automatic alb_alu_type sub8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                       input logic bi);
    alb_alu_type r;
    r.res = a - b - {7'h00, bi};
    r.h = (~a[3] & b[3]) | (b[3] & r.res[3]) | (r.res[3] & ~a[3]);
    r.c = (~a[7] & b[7]) | (b[7] & r.res[7]) | (r.res[7] & ~a[7]);
    r.v = (a[7] & ~b[7] & ~r.res[7]) | (~a[7] & b[7] & r.res[7]);
    r.n = r.res[7];
    r.z = (r.res == 8'h00);
    return r;
  endfunction : sub8

  // merge arithmetic flags Z C N V H into the status register
  function automatic logic [DATA_W-1:0] arith_flags(input logic [DATA_W-1:0] s, input alb_alu_type r);
    logic [DATA_W-1:0] o;
    o = s;
    o[SR_H] = r.h;
    o[SR_V] = r.v;
    o[SR_N] = r.n;
    o[SR_Z] = r.z;
    o[SR_C] = r.c;
    return o;
  endfunction : arith_flags

  // merge logic flags Z N V into the status register, V always cleared
  function automatic logic [DATA_W-1:0] logic_flags(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] r);
    logic [DATA_W-1:0] o;
    o = s;
    o[SR_V] = 1'b0;
    o[SR_N] = r[7];
    o[SR_Z] = (r == 8'h00);
    return o;
  endfunction : logic_flags

  // merge word flags Z C N V S into the status register
  function automatic logic [DATA_W-1:0] word_flags(input logic [DATA_W-1:0] s, input logic [WORD_W-1:0] r,
                                                   input logic v, input logic c);
    logic [DATA_W-1:0] o;
    o = s;
    o[SR_V] = v;
    o[SR_C] = c;
    o[SR_N] = r[15];
    o[SR_Z] = (r == 16'h0000);
    o[SR_S] = r[15] ^ v;
    return o;
  endfunction : word_flags

  // skip step: one word or two words over the next instruction
  function automatic logic [PC_W-1:0] skip_step(input logic two_word);
    return two_word ? PC_STEP3 : PC_STEP2;
  endfunction : skip_step

  // skip cycle count matching the skip step
  function automatic logic [CNT_W-1:0] skip_cycles(input logic two_word);
    return two_word ? CYC_THREE : CYC_TWO;
  endfunction : skip_cycles

  assign accept = cmd_valid_i && (state == st_idle);
  assign commit = (accept && (next_cycles == CYC_ONE)) || ((state == st_wait) && (cnt == CYC_ONE));

  // decode and compute the whole effect of the incoming instruction
  always_comb begin
    alb_alu_type r;
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] kw;
    logic [DATA_W-1:0] io_cur;
    logic [DATA_W-1:0] bit_mask;
    r = '0;
    kw = {10'h000, cmd_i.imm[5:0] & WORD_IMM_MASK};
    w = '0;
    bit_mask = 8'h01 << cmd_i.bit_sel;
    io_cur = (cmd_i.io_addr == FLAG_REG_ADDR) ? flag_state : cmd_i.io_rdata;
    next_wb = '0;
    next_sreg = sreg_o;
    next_pc = pc_o + PC_STEP1;
    next_io = '0;
    next_refused = 1'b0;
    next_push = 1'b0;
    next_pop = 1'b0;
    next_cycles = CYC_ONE;
    case (cmd_i.op)
      op_add, op_add_carry: begin
        r = add8(cmd_i.dest_val, cmd_i.source_reg, (cmd_i.op == op_add_carry) & sreg_o[SR_C]);
        next_wb = '{en: 1'b1, word: 1'b0, data: {8'h00, r.res}};
        next_sreg = arith_flags(sreg_o, r);
      end
      op_subtract, op_subtract_with_carry: begin
        r = sub8(cmd_i.dest_val, cmd_i.source_reg, (cmd_i.op == op_subtract_with_carry) & sreg_o[SR_C]);
        next_wb = '{en: 1'b1, word: 1'b0, data: {8'h00, r.res}};
        next_sreg = arith_flags(sreg_o, r);
      end
      op_subtract_immediate, op_subtract_carry_immediate, op_compare_immediate: begin
        r = sub8(cmd_i.dest_val, cmd_i.imm, (cmd_i.op == op_subtract_carry_immediate) & sreg_o[SR_C]);
        next_wb = '{en: (cmd_i.op != op_compare_immediate), word: 1'b0, data: {8'h00, r.res}};
        next_sreg = arith_flags(sreg_o, r);
      end
      op_add_immediate_word: begin
        w = cmd_i.pair_val + kw;
        next_wb = '{en: 1'b1, word: 1'b1, data: w};
        next_sreg = word_flags(sreg_o, w, ~cmd_i.pair_val[15] & w[15], ~w[15] & cmd_i.pair_val[15]);
        next_cycles = CYC_TWO;
      end
      op_subtract_immediate_word: begin
        w = cmd_i.pair_val - kw;
        next_wb = '{en: 1'b1, word: 1'b1, data: w};
        next_sreg = word_flags(sreg_o, w, cmd_i.pair_val[15] & ~w[15], w[15] & ~cmd_i.pair_val[15]);
        next_cycles = CYC_TWO;
      end
      op_bitwise_mask_immediate, op_bitwise_merge_immediate, op_set_bits_instruction,
      op_clear_bits_instruction: begin
        case (cmd_i.op)
          op_bitwise_mask_immediate: r.res = cmd_i.dest_val & cmd_i.imm;
          op_clear_bits_instruction: r.res = cmd_i.dest_val & (ALL_ONES - cmd_i.imm);
          default: r.res = cmd_i.dest_val | cmd_i.imm;
        endcase
        next_wb = '{en: 1'b1, word: 1'b0, data: {8'h00, r.res}};
        next_sreg = logic_flags(sreg_o, r.res);
      end
      op_compare_skip_equal: begin
        if (cmd_i.dest_val == cmd_i.source_reg) begin
          next_pc = pc_o + skip_step(cmd_i.next_two_word);
          next_cycles = skip_cycles(cmd_i.next_two_word);
        end
      end
      op_skip_if_bit_low: begin
        if ((cmd_i.source_reg & bit_mask) == 8'h00) begin
          next_pc = pc_o + skip_step(cmd_i.next_two_word);
          next_cycles = skip_cycles(cmd_i.next_two_word);
        end
      end
      op_indirect_jump: begin
        next_pc = cmd_i.z_ptr[PC_W-1:0];
        next_cycles = CYC_TWO;
      end
      op_indirect_call: begin
        next_pc = cmd_i.z_ptr[PC_W-1:0];
        next_push = 1'b1;
        next_cycles = CYC_THREE;
      end
      op_relative_jump, op_relative_call: begin
        next_pc = pc_o + PC_W'({{(PC_W-OFFS_W){cmd_i.rel_offs[OFFS_W-1]}}, cmd_i.rel_offs}) + PC_STEP1;
        next_push = (cmd_i.op == op_relative_call);
        next_cycles = (cmd_i.op == op_relative_call) ? CYC_THREE : CYC_TWO;
      end
      op_subroutine_return, op_interrupt_return: begin
        next_pc = stack_mem[sp - SP_W'(1)];
        next_pop = 1'b1;
        next_sreg[SR_I] = (cmd_i.op == op_interrupt_return) | sreg_o[SR_I];
        next_cycles = CYC_FOUR;
      end
      op_io_bit_set, op_io_bit_clear: begin
        next_cycles = CYC_TWO;
        if (cmd_i.io_addr > IO_BIT_LIMIT) begin
          next_refused = 1'b1;
        end else begin
          next_io.en = 1'b1;
          next_io.addr = cmd_i.io_addr;
          next_io.data = (cmd_i.op == op_io_bit_set) ? (io_cur | bit_mask) : (io_cur & ~bit_mask);
        end
      end
      default: begin
        next_cycles = CYC_ONE;
      end
    endcase
  end

  // sequencing: accept, wait out the cycle count, commit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= st_idle;
      cnt <= '0;
    end else begin
      case (state)
        st_idle: begin
          if (accept && (next_cycles != CYC_ONE)) begin
            state <= st_wait;
            cnt <= next_cycles - CYC_ONE;
          end
        end
        st_wait: begin
          cnt <= cnt - CYC_ONE;
          if (cnt == CYC_ONE) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // hold the computed effect while a multi-cycle instruction runs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_wb <= '0;
      pend_sreg <= SREG_RESET;
      pend_pc <= PC_RESET;
      pend_io <= '0;
      pend_refused <= 1'b0;
      pend_push <= 1'b0;
      pend_pop <= 1'b0;
    end else if (accept) begin
      pend_wb <= next_wb;
      pend_sreg <= next_sreg;
      pend_pc <= next_pc;
      pend_io <= next_io;
      pend_refused <= next_refused;
      pend_push <= next_push;
      pend_pop <= next_pop;
    end
  end

  // architectural state and result outputs, written at commit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_o <= '0;
      sreg_o <= SREG_RESET;
      pc_o <= PC_RESET;
      io_wr_o <= '0;
      io_refused_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= commit;
      wb_o <= '0;
      io_wr_o <= '0;
      io_refused_o <= 1'b0;
      if (commit) begin
        wb_o <= accept ? next_wb : pend_wb;
        sreg_o <= accept ? next_sreg : pend_sreg;
        pc_o <= accept ? next_pc : pend_pc;
        // i/o bit ops never finish in one clock, the internal flag register is kept off the port
        io_wr_o <= (accept || (pend_io.addr == FLAG_REG_ADDR)) ? alb_io_wr_type'('0) : pend_io;
        io_refused_o <= accept ? next_refused : pend_refused;
      end
    end
  end

  // ready low from accept of a multi-cycle instruction until its commit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (state == st_idle) ? !(accept && (next_cycles != CYC_ONE)) : (cnt == CYC_ONE);
    end
  end

  // return stack: push the address after a call, pop on return
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp <= '0;
    end else if (commit && pend_push && !accept) begin
      sp <= sp + SP_W'(1);
    end else if (commit && pend_pop && !accept) begin
      sp <= sp - SP_W'(1);
    end
  end

  // return address written at accept, pc_o still names the calling instruction
  always_ff @(posedge clock_i) begin
    if (accept && next_push) begin
      stack_mem[sp] <= pc_o + PC_STEP1;
    end
  end

  // internal write-one-to-clear status flags reached through the I/O bit ops
  assign flag_wr_en = commit && !accept && pend_io.en && (pend_io.addr == FLAG_REG_ADDR);
  assign flag_wr_data = pend_io.data;

  alb_w1c_flags #(
    .WIDTH(DATA_W)
  ) u_flags (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .set_i(flag_event_i),
    .wr_en_i(flag_wr_en),
    .wr_data_i(flag_wr_data),
    .flags_o(flag_state)
  );

  // flag state mirrored to a registered output
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_flags_o <= FLAGS_RESET;
    end else begin
      status_flags_o <= flag_state;
    end
  end
endmodule : alb_exec
`default_nettype wire

// ### alb_exec_assertions.sv
// checker of the execution unit port behaviour
`timescale 1ns/1ps
`default_nettype none
module alb_exec_checker
  import alb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic cmd_valid_i,
  input wire alb_cmd_type cmd_i,
  input wire logic ready_o,
  input wire logic done_o,
  input wire alb_wb_type wb_o,
  input wire logic [DATA_W-1:0] sreg_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire alb_io_wr_type io_wr_o,
  input wire logic io_refused_o
);
  // instruction taken at this edge
  wire logic take = cmd_valid_i && ready_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  add_one_cycle_a:
  assert property (take && cmd_i.op == op_add |=> done_o && wb_o.en) else $error("add late");
  add_carry_sum_a:
  assert property (take && cmd_i.op == op_add_carry |=> wb_o.data[7:0] ==
    $past(cmd_i.dest_val) + $past(cmd_i.source_reg) + $past(sreg_o[SR_C])) else $error("add carry sum wrong");
  word_two_cycle_a:
  assert property (take && cmd_i.op inside {op_add_immediate_word, op_subtract_immediate_word}
    |=> !done_o ##1 done_o && wb_o.word) else $error("word op timing wrong");
  jump_target_a:
  assert property (take && cmd_i.op == op_indirect_jump |-> ##2 pc_o == $past(cmd_i.z_ptr, 2)) else $error("jump pc");
  call_three_cycle_a:
  assert property (take && cmd_i.op == op_indirect_call |=> !done_o ##1 !done_o ##1
    done_o && pc_o == $past(cmd_i.z_ptr, 3)) else $error("call timing wrong");
  call_busy_span_a:
  assert property (take && cmd_i.op == op_relative_call |=> !ready_o ##1 !ready_o ##1 ready_o)
    else $error("call busy span wrong");
  branch_flags_kept_a:
  assert property (take && cmd_i.op inside {op_compare_skip_equal, op_skip_if_bit_low, op_indirect_jump}
    |=> $stable(sreg_o)) else $error("branch changed flags");
  logic_keeps_ch_a:
  assert property (take && cmd_i.op inside {op_bitwise_mask_immediate, op_bitwise_merge_immediate,
    op_set_bits_instruction, op_clear_bits_instruction} |=> sreg_o[SR_C] == $past(sreg_o[SR_C])
    && sreg_o[SR_H] == $past(sreg_o[SR_H]) && !sreg_o[SR_V]) else $error("logic op flags wrong");
  compare_no_store_a:
  assert property (take && cmd_i.op == op_compare_immediate |=> done_o && !wb_o.en) else $error("compare stored");
  interrupt_return_sets_i_a:
  assert property (take && cmd_i.op == op_interrupt_return |-> ##4 done_o && sreg_o[SR_I])
    else $error("interrupt return missed I");
  io_low_space_a:
  assert property (io_wr_o.en |-> done_o && io_wr_o.addr <= IO_BIT_LIMIT && io_wr_o.addr != FLAG_REG_ADDR)
    else $error("io write outside low space");
  io_refuse_quiet_a:
  assert property (io_refused_o |-> done_o && !io_wr_o.en && !wb_o.en) else $error("refused op wrote");
endmodule : alb_exec_checker
bind alb_exec alb_exec_checker #(.STACK_DEPTH(STACK_DEPTH)) chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .ready_o(ready_o), .done_o(done_o), .wb_o(wb_o),
  .sreg_o(sreg_o), .pc_o(pc_o), .io_wr_o(io_wr_o), .io_refused_o(io_refused_o));
`default_nettype wire

// ### alb_exec_tb.sv
// self-checking testbench of the execution unit
`timescale 1ns/1ps
`default_nettype none
module alb_exec_tb;
  import alb_pkg::*;
  // stimulus
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  alb_cmd_type cmd_i = '0;
  logic [DATA_W-1:0] flag_event_i = 8'h00;
  // observed outputs
  logic ready_o;
  logic done_o;
  logic io_refused_o;
  alb_wb_type wb_o;
  logic [DATA_W-1:0] sreg_o;
  logic [DATA_W-1:0] status_flags_o;
  logic [PC_W-1:0] pc_o;
  alb_io_wr_type io_wr_o;
  // bookkeeping
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [PC_W-1:0] exp_pc = 16'h0000;
  alb_wb_type seen_wb;
  alb_io_wr_type seen_io;
  logic seen_ref;

  alb_exec dut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .flag_event_i(flag_event_i),
    .ready_o(ready_o),
    .done_o(done_o),
    .wb_o(wb_o),
    .sreg_o(sreg_o),
    .pc_o(pc_o),
    .io_wr_o(io_wr_o),
    .io_refused_o(io_refused_o),
    .status_flags_o(status_flags_o)
  );

  // 50 ns clock
  always #25 clock_i = ~clock_i;

  // cut a hang short
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      test_done();
    end
  end

  // counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // compare one value with its expectation
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // offer one instruction, wait for done, keep the pulsed outputs
  task automatic issue(input alb_op_type op, input int cyc);
    int n;
    n = 0;
    cmd_i.op = op;
    cmd_valid_i = 1'b1;
    do begin
      @(negedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 8);
    seen_wb = wb_o;
    seen_io = io_wr_o;
    seen_ref = io_refused_o;
    cmd_valid_i = 1'b0;
    check(16'(n), 16'(cyc));
    @(negedge clock_i);
  endtask : issue

  // one-cycle arithmetic or logic instruction, flags C Z N V H
  task automatic alu(input alb_op_type op, input logic [7:0] d, input logic [7:0] k,
                     input logic [7:0] res, input logic [7:0] fl);
    cmd_i.dest_val = d;
    cmd_i.source_reg = k;
    cmd_i.imm = k;
    issue(op, 1);
    exp_pc = exp_pc + 16'h0001;
    check(16'(seen_wb.en), 16'(op != op_compare_immediate));
    if (op != op_compare_immediate) check(16'(seen_wb.data[7:0]), 16'(res));
    check(16'(sreg_o & 8'h2f), 16'(fl));
    check(pc_o, exp_pc);
  endtask : alu

  // word pair instruction, flags C Z N V S
  task automatic wop(input alb_op_type op, input logic [15:0] p, input logic [15:0] res, input logic [7:0] fl);
    cmd_i.pair_val = p;
    cmd_i.imm = 8'h01;
    issue(op, 2);
    exp_pc = exp_pc + 16'h0001;
    check(16'({seen_wb.en, seen_wb.word}), 16'h0003);
    check(seen_wb.data, res);
    check(16'(sreg_o & 8'h1f), 16'(fl));
  endtask : wop

  // skip instruction, the pc step equals the cycle count
  task automatic skp(input alb_op_type op, input logic [7:0] d, input logic [7:0] s, input logic [2:0] b,
                     input logic two, input int cyc);
    logic [7:0] sr;
    sr = sreg_o;
    cmd_i.dest_val = d;
    cmd_i.source_reg = s;
    cmd_i.bit_sel = b;
    cmd_i.next_two_word = two;
    issue(op, cyc);
    exp_pc = exp_pc + 16'(cyc);
    check(pc_o, exp_pc);
    check(16'(sreg_o), 16'(sr));
  endtask : skp

  // jump, call or return with its target
  task automatic jmp(input alb_op_type op, input logic [15:0] z, input logic [11:0] k, input int cyc,
                     input logic [15:0] tgt);
    logic [7:0] sr;
    sr = sreg_o | ((op == op_interrupt_return) ? 8'h80 : 8'h00);
    cmd_i.z_ptr = z;
    cmd_i.rel_offs = k;
    issue(op, cyc);
    exp_pc = tgt;
    check(pc_o, exp_pc);
    check(16'(sreg_o), 16'(sr));
  endtask : jmp

  // single bit set or clear in the i/o space
  task automatic iob(input alb_op_type op, input logic [5:0] a, input logic [2:0] b, input logic [7:0] rd,
                     input logic [7:0] wd, input logic wr, input logic rf);
    cmd_i.io_addr = a;
    cmd_i.bit_sel = b;
    cmd_i.io_rdata = rd;
    issue(op, 2);
    exp_pc = exp_pc + 16'h0001;
    check(16'({seen_io.en, seen_ref}), 16'({wr, rf}));
    if (wr) check(16'({seen_io.addr, seen_io.data}), 16'({a, wd}));
    check(pc_o, exp_pc);
  endtask : iob

  // main sequence
  initial begin
    repeat (10) @(negedge clock_i);
    check(16'({ready_o, done_o, sreg_o}), 16'h0000);
    check(pc_o, PC_RESET);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check(16'(ready_o), 16'h0001);
    $display("reset test done");
    alu(op_add, 8'h0f, 8'h01, 8'h10, 8'h20);
    alu(op_compare_immediate, 8'h10, 8'h20, 8'h00, 8'h05);
    alu(op_add_carry, 8'h7f, 8'h00, 8'h80, 8'h2c);
    alu(op_subtract, 8'h05, 8'h05, 8'h00, 8'h02);
    alu(op_subtract_immediate, 8'h00, 8'h01, 8'hff, 8'h25);
    alu(op_subtract_with_carry, 8'h10, 8'h00, 8'h0f, 8'h20);
    alu(op_subtract_carry_immediate, 8'h80, 8'h01, 8'h7f, 8'h28);
    alu(op_compare_immediate, 8'h00, 8'h01, 8'h00, 8'h25);
    alu(op_bitwise_mask_immediate, 8'hf3, 8'h0f, 8'h03, 8'h21);
    alu(op_bitwise_merge_immediate, 8'h80, 8'h01, 8'h81, 8'h25);
    alu(op_set_bits_instruction, 8'h00, 8'h00, 8'h00, 8'h23);
    alu(op_clear_bits_instruction, 8'hff, 8'h0f, 8'hf0, 8'h25);
    $display("alu test done");
    wop(op_add_immediate_word, 16'hffff, 16'h0000, 8'h03);
    wop(op_subtract_immediate_word, 16'h8000, 16'h7fff, 8'h18);
    $display("word test done");
    skp(op_compare_skip_equal, 8'h12, 8'h13, 3'h0, 1'b1, 1);
    skp(op_compare_skip_equal, 8'h12, 8'h12, 3'h0, 1'b0, 2);
    skp(op_compare_skip_equal, 8'h12, 8'h12, 3'h0, 1'b1, 3);
    skp(op_skip_if_bit_low, 8'h7f, 8'h7f, 3'h7, 1'b0, 2);
    skp(op_skip_if_bit_low, 8'h7f, 8'h7f, 3'h0, 1'b1, 1);
    skp(op_skip_if_bit_low, 8'h7f, 8'h7f, 3'h7, 1'b1, 3);
    $display("skip test done");
    jmp(op_relative_jump, 16'h0000, 12'hffe, 2, exp_pc - 16'h0001);
    jmp(op_indirect_jump, 16'h1234, 12'h000, 2, 16'h1234);
    jmp(op_relative_call, 16'h0000, 12'h010, 3, 16'h1245);
    jmp(op_indirect_call, 16'h2000, 12'h000, 3, 16'h2000);
    jmp(op_subroutine_return, 16'h0000, 12'h000, 4, 16'h1246);
    jmp(op_interrupt_return, 16'h0000, 12'h000, 4, 16'h1235);
    $display("branch test done");
    iob(op_io_bit_set, 6'h05, 3'h3, 8'h81, 8'h89, 1'b1, 1'b0);
    iob(op_io_bit_clear, 6'h1f, 3'h7, 8'h81, 8'h01, 1'b1, 1'b0);
    iob(op_io_bit_set, 6'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    $display("io test done");
    flag_event_i = 8'h05;
    @(negedge clock_i);
    flag_event_i = 8'h00;
    repeat (2) @(negedge clock_i);
    check(16'(status_flags_o), 16'h0005);
    iob(op_io_bit_clear, FLAG_REG_ADDR, 3'h2, 8'h00, 8'h00, 1'b0, 1'b0);
    @(negedge clock_i);
    check(16'(status_flags_o), 16'h0004);
    iob(op_io_bit_set, FLAG_REG_ADDR, 3'h1, 8'h00, 8'h00, 1'b0, 1'b0);
    @(negedge clock_i);
    check(16'(status_flags_o), 16'h0000);
    $display("flag test done");
    test_done();
  end
endmodule : alb_exec_tb
`default_nettype wire
